// ### verilog/cdfe_pkg.sv
// Constants, state codes and state record of the codec detect sequencer.
// Assumes a 100 MHz core clock and one synchronous reset.
package cdfe_pkg;
	// Ready wait limit in ms and clock rate in kHz
	localparam int TIMEOUT_MS = 600;
	localparam int CLK_KHZ    = 100000;
	// Ready wait limit in cycles
	localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
	localparam int TMR_W       = 26;
	// Codec register indices
	localparam logic [6:0] CREG_ID  = 7'h02;
	localparam logic [6:0] CREG_EXT = 7'h3C;
	// Configuration memory addresses
	localparam logic [7:0] MEM_APTR  = 8'h0E;
	localparam logic [7:0] MEM_SCAN0 = 8'h10;
	localparam logic [7:0] MEM_LAST  = 8'h2E;
	// Expected audio data byte count
	localparam logic [15:0] AUD_LEN = 16'h0008;
	// Software register byte offsets
	localparam logic [7:0] RA_CTRL = 8'h00;
	localparam logic [7:0] RA_STAT = 8'h04;
	localparam logic [7:0] RA_IRQ  = 8'h08;
	localparam logic [7:0] RA_MASK = 8'h0C;
	localparam logic [7:0] RA_PTR  = 8'h10;
	// Control bit and event bit positions
	localparam int CTRL_START = 0;
	localparam int EV_DONE    = 0;
	localparam int EV_TMO     = 1;
	localparam int EV_ILL     = 2;
	localparam int EV_MDM     = 3;
	localparam int EV_LEN     = 4;
	localparam int EV_W       = 5;
	// Codec kind codes: bit 0 audio, bit 1 modem
	localparam logic [1:0] CT_NONE  = 2'h0;
	localparam logic [1:0] CT_AUDIO = 2'h1;
	localparam logic [1:0] CT_MODEM = 2'h2;
	localparam logic [1:0] CT_COMB  = 2'h3;

	// Sequencer states
	typedef enum logic [3:0] {
		CDFE_IDLE   = 4'b0000,
		CDFE_WAITP  = 4'b0001,
		CDFE_WAITS  = 4'b0010,
		CDFE_CREG   = 4'b0011,
		CDFE_DECIDE = 4'b0100,
		CDFE_SAMPLE = 4'b0101,
		CDFE_MEM    = 4'b0110,
		CDFE_RESET  = 4'b0111,
		CDFE_NOTICE = 4'b1000
	} cdfe_state_t;

	// Whole state of the sequencer
	typedef struct packed {
		cdfe_state_t        st;
		logic               lrst_n;
		logic               aud;
		logic               mdm;
		logic               ctl;
		logic               busy;
		logic [TMR_W-1:0]   tmr;
		logic [2:0]         syp;
		logic [2:0]         sys;
		logic [2:0]         syc;
		logic               rp;
		logic               rs;
		logic               cdn;
		logic [1:0]         pt;
		logic [1:0]         stp;
		logic               sseen;
		logic [1:0]         step;
		logic               creq;
		logic [6:0]         cidx;
		logic               mreq;
		logic [7:0]         maddr;
		logic               scan;
		logic               hi;
		logic [15:0]        word;
		logic [15:0]        aptr;
		logic [15:0]        alen;
		logic               mpend;
		logic               nill;
		logic               nmdm;
		logic [EV_W-1:0]    ist;
		logic [EV_W-1:0]    imsk;
		logic               irq;
		logic [31:0]        rdata;
	} cdfe_regs_t;
endpackage

// ### verilog/cdfe_seq.sv
// Codec detect and function enable sequencer for an audio/modem link.
// Assumes codec register reads and configuration memory byte reads are
// served by same-clock logic; ready flags and the codec-down strap are pins.
//
// How it works
// [RULE1] Enable both functions, then release link reset
// [RULE2] Wait for slot 0 bit 15 ready
// [RULE3] Abandon ready wait after 600 ms
// [RULE4] Primary timeout skips secondary codec entirely
// [RULE5] Secondary timeout means primary only
// [RULE6] Identify primary at 00b, then secondary 01b
// [RULE7] Classify by registers 02h and 3Ch
// [RULE8] No primary disables whole link controller
// [RULE9] Audio primary alone or with audio: hide modem
// [RULE10] Modem primary alone: hide audio function
// [RULE11] Four combinations keep both functions enabled
// [RULE12] Modem primary with audio/modem secondary is illegal
// [RULE13] Combined/modem pairs: drop modem, raise notice
// [RULE14] Re-assert link reset after configuration
// [RULE15] Sample codec-down enable before extraction
// [RULE16] Audio pointer from bytes 0Eh, 0Fh
// [RULE17] Scan pointer words to 2Eh, subtract
// [RULE18] Audio data length must be eight bytes
// [RULE19] Notices stall until one-cycle acknowledge
`timescale 1ns/100ps
module cdfe_seq #(
	parameter int TIMEOUT_CYCLES = cdfe_pkg::TIMEOUT_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq,
	output logic             link_reset_n,
	output logic             audio_enable,
	output logic             modem_enable,
	output logic             ctrl_enable,
	input  wire logic        codec_ready_pri,
	input  wire logic        codec_ready_sec,
	input  wire logic        codec_down_enable_n,
	output logic             creg_req,
	output logic      [1:0]  creg_codec,
	output logic      [6:0]  creg_index,
	input  wire logic        creg_ack,
	input  wire logic [15:0] creg_data,
	output logic             mem_req,
	output logic      [7:0]  mem_addr,
	input  wire logic        mem_ack,
	input  wire logic [7:0]  mem_data,
	output logic             notice_illegal,
	output logic             notice_modem,
	input  wire logic        notice_ack
);
	// Last cycle of the ready wait
	localparam logic [cdfe_pkg::TMR_W-1:0] TMO_LAST =
		cdfe_pkg::TMR_W'(TIMEOUT_CYCLES - 1);
	localparam int TMO_INT = TIMEOUT_CYCLES;

	cdfe_pkg::cdfe_regs_t s;      // Registered state
	cdfe_pkg::cdfe_regs_t next_s; // Next state
	logic [cdfe_pkg::EV_W-1:0] ev;     // Events this cycle
	logic [cdfe_pkg::EV_W-1:0] clr;    // Software clears
	logic [15:0]               w;      // Assembled word
	logic                      nz;     // Codec register nonzero
	logic                      ctrl_wr; // Control register write seen

	// Outputs straight from the state flops
	assign reg_rdata      = s.rdata;
	assign irq            = s.irq;
	assign link_reset_n   = s.lrst_n;
	assign audio_enable   = s.aud;
	assign modem_enable   = s.mdm;
	assign ctrl_enable    = s.ctl;
	assign creg_req       = s.creq;
	assign creg_codec     = {1'b0, s.step[1]};
	assign creg_index     = s.cidx;
	assign mem_req        = s.mreq;
	assign mem_addr       = s.maddr;
	assign notice_illegal = s.nill;
	assign notice_modem   = s.nmdm;

	// Next-state logic
	always_comb
	begin
		next_s = s;
		ev = '0;
		w = {mem_data, s.word[7:0]};
		nz = (creg_data != 16'h0000);
		ctrl_wr = reg_wr && (reg_addr == cdfe_pkg::RA_CTRL);
		// Pin synchronisers, change taken when stages agree
		next_s.syp = {s.syp[1:0], codec_ready_pri};
		next_s.sys = {s.sys[1:0], codec_ready_sec};
		next_s.syc = {s.syc[1:0], codec_down_enable_n};
		if (s.syp[2] == s.syp[1])
			next_s.rp = s.syp[2];
		if (s.sys[2] == s.sys[1])
			next_s.rs = s.sys[2];
		if (s.syc[2] == s.syc[1])
			next_s.cdn = s.syc[2];
		// Register reads, data stands one cycle
		next_s.rdata = 32'h00000000;
		if (reg_rd)
		begin
			case (reg_addr)
				cdfe_pkg::RA_STAT:
					next_s.rdata = {16'h0000, 4'(s.st), s.nmdm,
						s.nill, s.stp, s.pt, s.cdn, s.lrst_n,
						s.ctl, s.mdm, s.aud, s.busy};
				cdfe_pkg::RA_IRQ:
					next_s.rdata = {27'h0, s.ist};
				cdfe_pkg::RA_MASK:
					next_s.rdata = {27'h0, s.imsk};
				cdfe_pkg::RA_PTR:
					next_s.rdata = {s.alen, s.aptr};
				// Control and unmapped read as zero
				default:
					next_s.rdata = 32'h00000000;
			endcase
		end

		case (s.st)
			// Wait for a start command
			cdfe_pkg::CDFE_IDLE:
			begin
				if (ctrl_wr && reg_wdata[cdfe_pkg::CTRL_START])
				begin
					// [RULE1] Enable functions first
					next_s.aud   = 1'b1;
					next_s.mdm   = 1'b1;
					next_s.ctl   = 1'b1;
					next_s.busy  = 1'b1;
					next_s.tmr   = '0;
					next_s.pt    = cdfe_pkg::CT_NONE;
					next_s.stp   = cdfe_pkg::CT_NONE;
					next_s.sseen = 1'b0;
					next_s.alen  = 16'h0000;
					next_s.aptr  = 16'h0000;
					next_s.st    = cdfe_pkg::CDFE_WAITP;
				end
			end
			// Primary ready wait
			cdfe_pkg::CDFE_WAITP:
			begin
				// [RULE1] Release link reset
				next_s.lrst_n = 1'b1;
				// [RULE2] Primary ready flag
				if (s.rp)
				begin
					next_s.tmr = '0;
					next_s.st  = cdfe_pkg::CDFE_WAITS;
				end
				// [RULE4] No secondary search
				else if (s.tmr == TMO_LAST)
				begin
					ev[cdfe_pkg::EV_TMO] = 1'b1;
					next_s.st = cdfe_pkg::CDFE_DECIDE;
				end
				// [RULE3] Bounded wait count
				else
					next_s.tmr = s.tmr + 1'b1;
			end
			// Secondary ready wait
			cdfe_pkg::CDFE_WAITS:
			begin
				// [RULE2] Secondary ready flag
				if (s.rs || s.tmr == TMO_LAST)
				begin
					// [RULE5] Timeout keeps primary only
					next_s.sseen = s.rs;
					ev[cdfe_pkg::EV_TMO] = !s.rs;
					next_s.step = 2'h0;
					next_s.creq = 1'b1;
					next_s.cidx = cdfe_pkg::CREG_ID;
					next_s.st   = cdfe_pkg::CDFE_CREG;
				end
				else
					next_s.tmr = s.tmr + 1'b1;
			end
			// Codec register reads, primary then secondary
			cdfe_pkg::CDFE_CREG:
			begin
				if (creg_ack)
				begin
					// [RULE7] Nonzero register marks a function
					case (s.step)
						2'h0: next_s.pt[0] = nz;
						2'h1: next_s.pt[1] = nz;
						2'h2: next_s.stp[0] = nz;
						default: next_s.stp[1] = nz;
					endcase
					// [RULE6] Secondary only after primary
					if (s.step == 2'h3 || (s.step == 2'h1 && !s.sseen))
					begin
						next_s.creq = 1'b0;
						next_s.st   = cdfe_pkg::CDFE_DECIDE;
					end
					else
					begin
						next_s.step = s.step + 2'h1;
						next_s.cidx = s.step[0] ? cdfe_pkg::CREG_ID
							: cdfe_pkg::CREG_EXT;
					end
				end
			end
			// Enable or disable functions by combination
			cdfe_pkg::CDFE_DECIDE:
			begin
				// [RULE8] No primary, controller off
				if (s.pt == cdfe_pkg::CT_NONE)
				begin
					next_s.ctl = 1'b0;
					next_s.aud = 1'b0;
					next_s.mdm = 1'b0;
					next_s.st  = cdfe_pkg::CDFE_RESET;
				end
				// [RULE12] Illegal pair, both off
				else if (s.pt == cdfe_pkg::CT_MODEM &&
					(s.stp == cdfe_pkg::CT_AUDIO ||
					s.stp == cdfe_pkg::CT_MODEM))
				begin
					next_s.aud  = 1'b0;
					next_s.mdm  = 1'b0;
					next_s.nill = 1'b1;
					ev[cdfe_pkg::EV_ILL] = 1'b1;
					next_s.st   = cdfe_pkg::CDFE_NOTICE;
				end
				else
				begin
					// [RULE9] Audio primary hides modem
					if (s.pt == cdfe_pkg::CT_AUDIO &&
						(s.stp == cdfe_pkg::CT_NONE ||
						s.stp == cdfe_pkg::CT_AUDIO))
						next_s.mdm = 1'b0;
					// [RULE10] Lone modem hides audio
					if (s.pt == cdfe_pkg::CT_MODEM &&
						s.stp == cdfe_pkg::CT_NONE)
						next_s.aud = 1'b0;
					// [RULE13] Modem dropped, notice later
					if ((s.pt == cdfe_pkg::CT_COMB &&
						s.stp[1]) || (s.pt == cdfe_pkg::CT_MODEM
						&& s.stp == cdfe_pkg::CT_COMB))
					begin
						next_s.mdm   = 1'b0;
						next_s.mpend = 1'b1;
					end
					// [RULE11] Other pairs keep both
					next_s.st = cdfe_pkg::CDFE_SAMPLE;
				end
			end
			// Decide where identification data lives
			cdfe_pkg::CDFE_SAMPLE:
			begin
				// [RULE15] Riser masters when strap high
				if (s.cdn && s.aud && (s.pt[0] || s.stp[0]))
				begin
					// [RULE16] Start at audio pointer bytes
					next_s.maddr = cdfe_pkg::MEM_APTR;
					next_s.mreq  = 1'b1;
					next_s.scan  = 1'b0;
					next_s.hi    = 1'b0;
					next_s.st    = cdfe_pkg::CDFE_MEM;
				end
				else
					next_s.st = cdfe_pkg::CDFE_RESET;
			end
			// Byte reads assembled into words, low byte first
			cdfe_pkg::CDFE_MEM:
			begin
				if (mem_ack)
				begin
					next_s.maddr = s.maddr + 8'h01;
					next_s.hi    = !s.hi;
					next_s.word  = s.hi ? w : {8'h00, mem_data};
					// [RULE16] Upper byte from odd address
					if (s.hi && !s.scan)
					begin
						next_s.aptr  = w;
						next_s.scan  = 1'b1;
						next_s.maddr = cdfe_pkg::MEM_SCAN0;
					end
					// [RULE17] Stop on nonzero or last word
					else if (s.hi && (w != 16'h0000 ||
						s.maddr[7:1] == cdfe_pkg::MEM_LAST[7:1]))
					begin
						next_s.alen = w - s.aptr;
						next_s.mreq = 1'b0;
						// [RULE18] Length check
						ev[cdfe_pkg::EV_LEN] =
							(w - s.aptr) != cdfe_pkg::AUD_LEN;
						next_s.st = cdfe_pkg::CDFE_RESET;
					end
				end
			end
			// Put the codecs back in reset
			cdfe_pkg::CDFE_RESET:
			begin
				// [RULE14] Reset again for beep pass-through
				next_s.lrst_n = 1'b0;
				if (s.mpend)
				begin
					// [RULE13] Modem-disabled notice
					next_s.mpend = 1'b0;
					next_s.nmdm  = 1'b1;
					ev[cdfe_pkg::EV_MDM] = 1'b1;
					next_s.st    = cdfe_pkg::CDFE_NOTICE;
				end
				else
				begin
					next_s.busy = 1'b0;
					ev[cdfe_pkg::EV_DONE] = 1'b1;
					next_s.st   = cdfe_pkg::CDFE_IDLE;
				end
			end
			// Stall until the user acknowledges
			cdfe_pkg::CDFE_NOTICE:
			begin
				// [RULE19] One-cycle acknowledge releases
				if (notice_ack)
				begin
					next_s.nill = 1'b0;
					next_s.nmdm = 1'b0;
					next_s.st   = cdfe_pkg::CDFE_RESET;
				end
			end
			default:
				next_s.st = cdfe_pkg::CDFE_IDLE;
		endcase

		// Sticky events, set wins over write-one clear
		clr = '0;
		if (reg_wr && reg_addr == cdfe_pkg::RA_IRQ)
			clr = reg_wdata[cdfe_pkg::EV_W-1:0];
		next_s.ist = (s.ist & ~clr) | ev;
		if (reg_wr && reg_addr == cdfe_pkg::RA_MASK)
			next_s.imsk = reg_wdata[cdfe_pkg::EV_W-1:0];
		next_s.irq = |(next_s.ist & next_s.imsk);
	end

	// State register, all zero on reset
	always_ff @(posedge core_clk)
	begin
		if (srst)
			s <= '0;
		else
			s <= next_s;
	end

	// Enables precede reset release
	chk_release_order: assert property (@(posedge core_clk) // [RULE1]
		disable iff (srst) $rose(link_reset_n) |->
		$past(audio_enable) && $past(modem_enable))
		else $error("link reset released before enables");

	// Ready moves on to the secondary wait
	chk_ready_advance: assert property (@(posedge core_clk) // [RULE2]
		disable iff (srst) s.st == cdfe_pkg::CDFE_WAITP && s.rp
		|=> s.st == cdfe_pkg::CDFE_WAITS)
		else $error("primary ready not taken");

	// Wait counter stays below the limit
	chk_wait_bound: assert property (@(posedge core_clk) // [RULE3]
		disable iff (srst) int'(s.tmr) < TMO_INT)
		else $error("ready wait overran its limit");

	// Primary timeout skips the secondary
	chk_no_secondary: assert property (@(posedge core_clk) // [RULE4]
		disable iff (srst) s.st == cdfe_pkg::CDFE_WAITP && !s.rp
		&& s.tmr == TMO_LAST |=> s.st == cdfe_pkg::CDFE_DECIDE)
		else $error("primary timeout did not skip secondary");

	// Secondary timeout leaves primary only
	chk_sec_timeout: assert property (@(posedge core_clk) // [RULE5]
		disable iff (srst) s.st == cdfe_pkg::CDFE_WAITS && !s.rs
		&& s.tmr == TMO_LAST |=> !s.sseen && s.ist[cdfe_pkg::EV_TMO])
		else $error("secondary timeout mishandled");

	// Codec address follows read step
	chk_codec_addr: assert property (@(posedge core_clk) // [RULE6]
		disable iff (srst) creg_req && creg_codec == 2'h1
		|-> s.sseen && s.step >= 2'h2)
		else $error("secondary addressed too early");

	// Missing primary turns controller off
	chk_no_primary: assert property (@(posedge core_clk) // [RULE8]
		disable iff (srst) s.st == cdfe_pkg::CDFE_DECIDE
		&& s.pt == cdfe_pkg::CT_NONE |=> !ctrl_enable ##1 !link_reset_n)
		else $error("controller left on without primary");

	// Illegal notice keeps both functions off
	chk_illegal_off: assert property (@(posedge core_clk) // [RULE12]
		disable iff (srst) notice_illegal |-> !audio_enable
		&& !modem_enable && s.st == cdfe_pkg::CDFE_NOTICE)
		else $error("illegal pair left a function on");

	// Modem notice only with modem off
	chk_modem_notice: assert property (@(posedge core_clk) // [RULE13]
		disable iff (srst) $rose(notice_modem) |->
		!modem_enable && !link_reset_n)
		else $error("modem notice with modem enabled");

	// Link reset asserted after configuration
	chk_reset_again: assert property (@(posedge core_clk) // [RULE14]
		disable iff (srst) s.st == cdfe_pkg::CDFE_RESET
		|=> !link_reset_n)
		else $error("link reset not re-asserted");

	// Stall holds until acknowledge
	chk_notice_stall: assert property (@(posedge core_clk) // [RULE19]
		disable iff (srst) s.st == cdfe_pkg::CDFE_NOTICE && !notice_ack
		|=> s.st == cdfe_pkg::CDFE_NOTICE)
		else $error("notice released without acknowledge");
endmodule // cdfe_seq

// ### dv/cdfe_codec_model.sv
// Behavioural codecs and configuration memory on the far side of the link.
// Assumes the bench sets codec kinds, pointer words and answer latency.
`timescale 1ns/100ps
module cdfe_codec_model (
	input  wire logic        core_clk,
	input  wire logic        link_reset_n,
	input  wire logic [1:0]  pri_kind,
	input  wire logic [1:0]  sec_kind,
	input  wire logic [15:0] aptr,
	input  wire logic [15:0] nxt,
	input  wire logic [1:0]  lat,
	output logic             codec_ready_pri,
	output logic             codec_ready_sec,
	input  wire logic        creg_req,
	input  wire logic [1:0]  creg_codec,
	input  wire logic [6:0]  creg_index,
	output logic             creg_ack,
	output logic      [15:0] creg_data,
	input  wire logic        mem_req,
	input  wire logic [7:0]  mem_addr,
	output logic             mem_ack,
	output logic      [7:0]  mem_data
);
	logic [3:0] up; // Cycles since link reset release
	logic [1:0] cc; // Codec answer delay
	logic [1:0] mc; // Memory answer delay
	logic [1:0] k;  // Kind of addressed codec
	assign k = creg_codec[0] ? sec_kind : pri_kind;
	// Quiet start
	initial
	begin
		{up, cc, mc, codec_ready_pri, codec_ready_sec} = '0;
		{creg_ack, creg_data, mem_ack, mem_data} = '0;
	end
	always @(posedge core_clk)
	begin
		up <= !link_reset_n ? 4'h0 : (up == 4'hF ? up : up + 4'h1);
		codec_ready_pri <= link_reset_n && up > 4'h3 && pri_kind != 2'h0;
		codec_ready_sec <= link_reset_n && up > 4'h5 && sec_kind != 2'h0;
	end
	// 02h nonzero for audio, 3Ch for modem
	always @(posedge core_clk)
	begin
		creg_ack <= 1'b0;
		creg_data <= ~creg_data;
		cc <= creg_req && !creg_ack ? cc + 2'h1 : 2'h0;
		if (creg_req && !creg_ack && cc == lat)
		begin
			creg_ack <= 1'b1;
			creg_data <= (creg_index == cdfe_pkg::CREG_ID ? k[0] : k[1])
				? 16'h5A01 : 16'h0000;
		end
	end
	always @(posedge core_clk)
	begin
		mem_ack <= 1'b0;
		mem_data <= ~mem_data;
		mc <= mem_req && !mem_ack ? mc + 2'h1 : 2'h0;
		if (mem_req && !mem_ack && mc == lat)
		begin
			mem_ack <= 1'b1;
			case (mem_addr)
				8'h0E: mem_data <= aptr[7:0];
				8'h0F: mem_data <= aptr[15:8];
				8'h10: mem_data <= nxt[7:0];
				8'h11: mem_data <= nxt[15:8];
				default: mem_data <= 8'h00;
			endcase
		end
	end
endmodule // cdfe_codec_model

// ### dv/tb_cdfe_seq.sv
// Self-checking bench for the codec detect sequencer.
// Assumes a short ready timeout and the behavioural far-side model.
`timescale 1ns/100ps
module tb_cdfe_seq;
	logic        core_clk, srst, reg_wr, reg_rd, irq, rd_d;
	logic [7:0]  reg_addr, mem_addr, mem_data;
	logic [31:0] reg_wdata, reg_rdata;
	logic        link_reset_n, audio_enable, modem_enable, ctrl_enable;
	logic        rdy_p, rdy_s, codec_down_enable_n, creg_req, creg_ack;
	logic [1:0]  creg_codec, pri_kind, sec_kind, lat;
	logic [6:0]  creg_index;
	logic [15:0] creg_data, aptr, nxt;
	logic        mem_req, mem_ack, notice_illegal, notice_modem, notice_ack;
	int          failures, n_compared, cyc;
	logic [31:0] exp_q[$]; // Expected read data
	logic [31:0] msk_q[$]; // Bits that matter
	// Combination table: primary, secondary, audio, modem, notice
	logic [7:0]  tbl [13] = '{8'h10, 8'h48, 8'h84, 8'hCC, 8'h58, 8'h91,
		8'hDC, 8'h6C, 8'hA1, 8'hEA, 8'h7C, 8'hBA, 8'hFA};

	cdfe_seq #(.TIMEOUT_CYCLES(50)) dut_u (.core_clk(core_clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.link_reset_n(link_reset_n), .audio_enable(audio_enable),
		.modem_enable(modem_enable), .ctrl_enable(ctrl_enable),
		.codec_ready_pri(rdy_p), .codec_ready_sec(rdy_s),
		.codec_down_enable_n(codec_down_enable_n), .creg_req(creg_req),
		.creg_codec(creg_codec), .creg_index(creg_index),
		.creg_ack(creg_ack), .creg_data(creg_data), .mem_req(mem_req),
		.mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data),
		.notice_illegal(notice_illegal), .notice_modem(notice_modem),
		.notice_ack(notice_ack));
	cdfe_codec_model model_u (.core_clk(core_clk),
		.link_reset_n(link_reset_n), .pri_kind(pri_kind),
		.sec_kind(sec_kind), .aptr(aptr), .nxt(nxt), .lat(lat),
		.codec_ready_pri(rdy_p), .codec_ready_sec(rdy_s),
		.creg_req(creg_req), .creg_codec(creg_codec),
		.creg_index(creg_index), .creg_ack(creg_ack),
		.creg_data(creg_data), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_ack(mem_ack), .mem_data(mem_data));

	// Free-running core clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// Single comparison, counted
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			failures++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// One-cycle register write, then a gap cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	// Register read; expectation goes to the queue
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		exp_q.push_back(e & m);
		msk_q.push_back(m);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
	endtask
	// Interrupt line one edge after the write has landed
	task automatic chk_irq(input logic e);
		@(posedge core_clk);
		cmp({31'h0, irq}, {31'h0, e});
	endtask
	// Read data watcher: oldest note against the answer cycle
	always @(posedge core_clk)
	begin
		if (rd_d)
			cmp(reg_rdata & msk_q.pop_front(), exp_q.pop_front());
		rd_d <= reg_rd;
	end
	// One boot sequence for one codec combination
	task automatic run(input logic [7:0] t);
		logic [1:0]  p, s, seen;
		logic [15:0] a, w, ln;
		logic        ext, strap;
		int          n, sel;
		logic [31:0] se;
		p = t[7:6];
		s = p == 2'h0 ? 2'h0 : t[5:4];
		a = {1'b0, 15'($urandom)};
		sel = $urandom % 3;
		w = sel == 2 ? 16'h0000 : a + (sel == 0 ? 16'h0008 : 16'h000C);
		ln = w - a;
		strap = 1'($urandom);
		ext = strap && t[3] && (p[0] || s[0]);
		pri_kind <= p;
		sec_kind <= t[5:4];
		aptr <= a;
		nxt <= w;
		lat <= 2'($urandom);
		codec_down_enable_n <= strap;
		wr(cdfe_pkg::RA_CTRL, 32'h1);
		for (n = 0; !link_reset_n && n < 20; n++)
			@(posedge core_clk);
		cmp({30'h0, audio_enable, modem_enable}, 32'h3);
		seen = 2'h0;
		for (n = 0; !irq && n < 3000; n++)
		begin
			@(posedge core_clk);
			if (notice_illegal || notice_modem)
			begin
				seen = {notice_modem, notice_illegal};
				cmp({31'h0, link_reset_n}, {31'h0, notice_illegal});
				cmp({30'h0, audio_enable, modem_enable},
					{30'h0, notice_modem, 1'b0});
				notice_ack <= 1'b1;
				@(posedge core_clk);
				notice_ack <= 1'b0;
				@(posedge core_clk);
			end
		end
		cmp({30'h0, seen}, {30'h0, t[1:0]});
		// Expected status: kinds, strap, reset, enables, idle
		se = {20'h0, 2'h0, s, p, strap, 1'b0, p != 2'h0, t[2], t[3], 1'b0};
		rd(cdfe_pkg::RA_STAT, se, 32'h3C0);
		rd(cdfe_pkg::RA_STAT, se, 32'h00F);
		rd(cdfe_pkg::RA_STAT, se, 32'hC36);
		if (ext)
			rd(cdfe_pkg::RA_PTR, {ln, a}, 32'hFFFFFFFF);
		// Timeout bit: primary or secondary never became ready
		rd(cdfe_pkg::RA_IRQ, {27'h0, ext && ln != 16'h8, t[1:0] == 2'h2,
			t[1:0] == 2'h1, s == 2'h0, 1'b1}, 32'h1F);
		wr(cdfe_pkg::RA_MASK, 32'h0);
		chk_irq(1'b0);
		wr(cdfe_pkg::RA_MASK, 32'h1);
		chk_irq(1'b1);
		wr(cdfe_pkg::RA_IRQ, 32'h1F);
		chk_irq(1'b0);
		rd(cdfe_pkg::RA_IRQ, 32'h0, 32'h1F);
	endtask
	// Verdict and end of run
	task automatic summarize();
		$display("Compared %0d, mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Hang guard
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			failures++;
			summarize();
		end
	end
	// Main sequence
	initial
	begin
		{reg_wr, reg_rd, rd_d, notice_ack, codec_down_enable_n} = '0;
		{reg_addr, reg_wdata, pri_kind, sec_kind, lat, aptr, nxt} = '0;
		{failures, n_compared, cyc} = '0;
		srst = 1'b1;
		cyc = $urandom(75440);
		cyc = 0;
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		repeat (4) @(posedge core_clk);
		wr(cdfe_pkg::RA_MASK, 32'h1);
		rd(cdfe_pkg::RA_CTRL, 32'h0, 32'hFFFFFFFF);
		rd(8'h20, 32'h0, 32'hFFFFFFFF);
		for (int r = 0; r < 2; r++)
			foreach (tbl[i])
				run(tbl[i]);
		repeat (4) @(posedge core_clk);
		summarize();
	end
endmodule // tb_cdfe_seq
